// [core/clock_mgmt_pkg.sv]
`default_nettype none
package clock_mgmt_pkg;
  // System clock
  localparam int unsigned CLK_HZ        = 25_000_000;
  localparam int unsigned CLK_PERIOD_NS = 1_000_000_000 / CLK_HZ;

  // Register map (byte addresses)
  localparam int unsigned ADR_W       = 4;
  localparam logic [3:0]  CTRL_ADDR   = 4'h0;
  localparam logic [3:0]  STATUS_ADDR = 4'h4;

  // Control register fields
  localparam int TRIM_LSB        = 0;
  localparam int SPREAD_EN_BIT   = 4;
  localparam int CARRIER_SEL_BIT = 5;
  localparam int DIV_SEL_BIT     = 6;
  localparam int ROUTE_SEL_BIT   = 7;
  localparam int OUT_BASE_BIT    = 8;
  localparam int OUT_SEL_LSB     = 12;

  // Status register fields
  localparam int ST_RANGE_OK_BIT = 0;
  localparam int ST_LOCKED_BIT   = 1;
  localparam int ST_BASE_PLL_BIT = 2;
  localparam int ST_PLL_OPT_BIT  = 3;

  // Oscillator trim
  localparam logic [3:0] TRIM_DEFAULT = 4'h0;
  localparam logic [4:0] NOMINAL_MHZ  = 5'h14;

  function automatic logic [4:0] trim_to_mhz(input logic [3:0] code);
    case (code)
      4'h1:    return 5'h15;
      4'h2:    return 5'h16;
      4'h3:    return 5'h17;
      4'h4:    return 5'h18;
      4'h9:    return 5'h10;
      4'hA:    return 5'h11;
      4'hB:    return 5'h12;
      4'hC:    return 5'h13;
      default: return NOMINAL_MHZ;
    endcase
  endfunction

  // Numerically controlled oscillator
  localparam int unsigned NCO_W       = 24;
  localparam int unsigned INC_PER_MHZ = (2 ** NCO_W) / (CLK_HZ / 1_000_000);

  // Dividers
  localparam int unsigned FAST_DIV     = 9;
  localparam int unsigned SLOW_DIV     = 44;
  localparam int unsigned DIAG_DIV     = 48;
  localparam int unsigned SYNC_PRE_DIV = 6;
  localparam int unsigned PLL_MULT     = 48;

  // Spread spectrum
  localparam int unsigned CARRIER_SLOW_HZ = 23_000;
  localparam int unsigned CARRIER_FAST_HZ = 94_000;
  localparam int unsigned TRI_AMPL        = 32;
  localparam int unsigned SS_STEP_SLOW    = CLK_HZ / (CARRIER_SLOW_HZ * 4 * TRI_AMPL);
  localparam int unsigned SS_STEP_FAST    = CLK_HZ / (CARRIER_FAST_HZ * 4 * TRI_AMPL);
  localparam int unsigned SS_DEV_NUM      = 51;
  localparam int unsigned SS_DEV_SHIFT    = 15;

  // Sync-in supervision times
  localparam int unsigned PERIOD_MIN_NS  = 2000;
  localparam int unsigned PERIOD_MAX_NS  = 3003;
  localparam int unsigned LOSS_NS        = 3000;
  localparam int unsigned LOCK_NS        = 90_000;
  localparam int unsigned PERIOD_MIN_CYC = (PERIOD_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned PERIOD_MAX_CYC = PERIOD_MAX_NS / CLK_PERIOD_NS;
  localparam int unsigned LOSS_CYC       = LOSS_NS / CLK_PERIOD_NS;
  localparam int unsigned LOCK_CYC       = LOCK_NS / CLK_PERIOD_NS;

  // Regulators and sync-out selection codes
  localparam int unsigned REG_COUNT    = 5;
  localparam logic [3:0]  OUT_OFF      = 4'h0;
  localparam logic [3:0]  OUT_REG_LAST = 4'h5;
  localparam logic [3:0]  OUT_BASE     = 4'h6;
  localparam logic [3:0]  OUT_MAIN_DIV = 4'h7;
  localparam logic [3:0]  OUT_FS_DIV   = 4'h8;
  localparam logic [3:0]  OUT_SYNC_DIV = 4'h9;
endpackage
`default_nettype wire

// [core/sync_mon_if.sv]
`default_nettype none
interface sync_mon_if;
  logic enable;
  logic div_sel;
  logic div_clk;
  logic fault;
  logic locked;
  logic pll_tick;

  modport manager (output enable, output div_sel,
                   input div_clk, input fault, input locked, input pll_tick);
  modport monitor (input enable, input div_sel,
                   output div_clk, output fault, output locked, output pll_tick);
endinterface
`default_nettype wire

// [core/regulator_phase_shift.sv]
`default_nettype none
module regulator_phase_shift
  import clock_mgmt_pkg::*;
#(
  parameter int unsigned SHIFT_W = 3
) (
  // Clock and reset
  input  wire logic               clk,
  input  wire logic               rst_n,
  // Base clock, source and shift
  input  wire logic               base_tick,
  input  wire logic               src_clk,
  input  wire logic [SHIFT_W-1:0] shift,
  // Shifted clock and its start pulse
  output logic                    clk_out,
  output logic                    start
);
  if (SHIFT_W < 1 || SHIFT_W > 4) begin : g_check
    $error("regulator_phase_shift: SHIFT_W out of range");
  end

  typedef struct packed {
    logic [2**SHIFT_W-1:0] hist;
    logic                  clk_out;
    logic                  start;
  } ps_state_t;

  ps_state_t s_q;
  ps_state_t s_d;

  always_comb begin
    s_d       = s_q;
    s_d.start = 1'b0;
    // Shift history advances only on base clock cycles, so a count of n is n base periods
    if (base_tick) begin
      s_d.hist    = {s_q.hist[2**SHIFT_W-2:0], src_clk};
      s_d.clk_out = s_d.hist[shift];
      s_d.start   = s_d.clk_out & ~s_q.clk_out;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign clk_out = s_q.clk_out;
  assign start   = s_q.start;
endmodule
`default_nettype wire

// [core/sync_in_monitor.sv]
`default_nettype none
module sync_in_monitor
  import clock_mgmt_pkg::*;
#(
  parameter int unsigned CNT_W = 12
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // External sync input
  input  wire logic sync_in,
  // Link to the clock manager
  sync_mon_if.monitor mon
);
  if (2 ** CNT_W <= LOCK_CYC || 2 ** CNT_W <= LOSS_CYC) begin : g_check
    $error("sync_in_monitor: CNT_W too small");
  end

  typedef struct packed {
    logic             pin_q;
    logic [2:0]       pre_cnt;
    logic             div_clk;
    logic [CNT_W-1:0] per_cnt;
    logic [7:0]       period;
    logic             seen;
    logic [8:0]       acc;
    logic [CNT_W-1:0] lock_cnt;
    logic             locked;
    logic             fault;
    logic             tick;
  } mon_state_t;

  mon_state_t s_q;
  mon_state_t s_d;
  logic       rise;
  logic       div_rise;

  always_comb begin
    s_d       = s_q;
    s_d.fault = 1'b0;
    s_d.tick  = 1'b0;
    s_d.pin_q = sync_in;
    rise      = sync_in & ~s_q.pin_q;
    div_rise  = rise & (~mon.div_sel | (s_q.pre_cnt == 3'(SYNC_PRE_DIV - 1)));
    if (rise) begin
      s_d.pre_cnt = (s_q.pre_cnt == 3'(SYNC_PRE_DIV - 1)) ? 3'h0 : s_q.pre_cnt + 3'h1;
    end
    s_d.div_clk = mon.div_sel ? (s_d.pre_cnt < 3'(SYNC_PRE_DIV / 2)) : sync_in;
    if (!mon.enable) begin
      s_d.per_cnt  = '0;
      s_d.seen     = 1'b0;
      s_d.acc      = '0;
      s_d.lock_cnt = '0;
      s_d.locked   = 1'b0;
    end else begin
      if (div_rise) begin
        // Every period is judged, so short glitches fail at the next edge
        if (s_q.seen && (s_q.per_cnt < CNT_W'(PERIOD_MIN_CYC)
                         || s_q.per_cnt > CNT_W'(PERIOD_MAX_CYC))) begin
          s_d.fault = 1'b1;
        end
        s_d.period  = 8'(s_q.per_cnt);
        s_d.seen    = 1'b1;
        s_d.per_cnt = CNT_W'(1);
      end else if (s_q.per_cnt >= CNT_W'(LOSS_CYC)) begin
        s_d.fault = 1'b1;
      end else begin
        s_d.per_cnt = s_q.per_cnt + CNT_W'(1);
      end
      // Rate follower: PLL_MULT base ticks per measured sync period
      if (s_q.seen) begin
        s_d.acc = s_q.acc + 9'(PLL_MULT);
        if (s_d.acc >= {1'b0, s_q.period}) begin
          s_d.acc  = s_d.acc - {1'b0, s_q.period};
          s_d.tick = 1'b1;
        end
        if (s_q.lock_cnt < CNT_W'(LOCK_CYC)) begin
          s_d.lock_cnt = s_q.lock_cnt + CNT_W'(1);
        end else begin
          s_d.locked = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign mon.div_clk  = s_q.div_clk;
  assign mon.fault    = s_q.fault;
  assign mon.locked   = s_q.locked;
  assign mon.pll_tick = s_q.tick;
endmodule
`default_nettype wire

// [core/switcher_clock_management.sv]
// Design decisions made here: the address map and the Wishbone slave port.
`default_nettype none
module switcher_clock_management
  import clock_mgmt_pkg::*;
(
  // Clock and reset
  input  wire logic                  CLK,
  input  wire logic                  RST_N,
  // Wishbone slave
  input  wire logic                  WB_CYC_I,
  input  wire logic                  WB_STB_I,
  input  wire logic                  WB_WE_I,
  input  wire logic [ADR_W-1:0]      WB_ADR_I,
  input  wire logic [3:0]            WB_SEL_I,
  input  wire logic [31:0]           WB_DAT_I,
  output logic                       WB_ACK_O,
  output logic [31:0]                WB_DAT_O,
  // One-time-programmed options
  input  wire logic [2:0]            PRE_REGULATOR_PHASE_SHIFT,
  input  wire logic [2:0]            STEP_UP_PHASE_SHIFT,
  input  wire logic [2:0]            CORE_CONVERTER1_PHASE_SHIFT,
  input  wire logic [2:0]            CORE_CONVERTER2_PHASE_SHIFT,
  input  wire logic [2:0]            CORE_CONVERTER3_PHASE_SHIFT,
  input  wire logic                  PRE_REGULATOR_SLOW_SELECT,
  input  wire logic                  PLL_OPTION_ENABLE,
  // Synchronisation pins
  input  wire logic                  SYNC_IN_PIN,
  output logic                       SYNC_OUT_PIN,
  // Regulator switching clocks
  output logic                       PRE_REGULATOR_CLOCK,
  output logic                       STEP_UP_CLOCK,
  output logic                       CORE_CONVERTER1_CLOCK,
  output logic                       CORE_CONVERTER2_CLOCK,
  output logic                       CORE_CONVERTER3_CLOCK,
  // Switch on-time start pulses
  output logic                       PRE_REGULATOR_HS_START,
  output logic                       CORE_CONVERTER3_HS_START,
  output logic                       CORE_CONVERTER1_LS_START,
  output logic                       CORE_CONVERTER2_LS_START,
  output logic                       STEP_UP_SWITCH_START
);
  typedef struct packed {
    logic [3:0]       trim;
    logic [3:0]       trim_eff;
    logic             spread_en;
    logic             carrier_sel;
    logic             div_sel;
    logic             route_sel;
    logic             out_base_sel;
    logic [3:0]       out_sel;
    logic             out_base_eff;
    logic [3:0]       out_sel_eff;
    logic             range_ok;
    logic             use_pll;
    logic [NCO_W-1:0] nco;
    logic [NCO_W-1:0] fs_nco;
    logic [6:0]       tri_val;
    logic             tri_down;
    logic [3:0]       tri_pre;
    logic [3:0]       fast_cnt;
    logic             fast_clk;
    logic [5:0]       slow_cnt;
    logic             slow_clk;
    logic [4:0]       main_cnt;
    logic             main_div;
    logic [4:0]       fs_cnt;
    logic             fs_div;
    logic             sync_out;
    logic             ack;
    logic [31:0]      dat;
  } cm_state_t;

  localparam cm_state_t CM_RESET = '{trim: TRIM_DEFAULT, trim_eff: TRIM_DEFAULT,
                                     range_ok: 1'b1, default: '0};
  localparam logic signed [39:0] SS_NUM   = 40'(SS_DEV_NUM);
  localparam logic [NCO_W-1:0]   FS_INC   = NCO_W'(NOMINAL_MHZ * INC_PER_MHZ);
  localparam logic signed [6:0]  TRI_TOP  = 7'(TRI_AMPL);
  localparam logic signed [6:0]  TRI_BOT  = -7'(TRI_AMPL);

  cm_state_t s_q;
  cm_state_t s_d;

  sync_mon_if mon_if ();

  logic [NCO_W-1:0]           inc0;
  logic signed [39:0]         ss_prod;
  logic signed [39:0]         inc_sum;
  logic [NCO_W:0]             nco_sum;
  logic [NCO_W:0]             fs_sum;
  logic                       osc_tick;
  logic                       fs_tick;
  logic                       base_tick;
  logic [3:0]                 ss_step;
  logic [15:0]                ctrl_rd;
  logic [15:0]                ctrl_wr;
  logic [31:0]                rd_word;
  logic                       req;
  logic                       out_src;
  logic [REG_COUNT-1:0]       reg_src;
  logic [REG_COUNT-1:0]       reg_clk;
  logic [REG_COUNT-1:0]       reg_start;
  logic [REG_COUNT-1:0][2:0]  reg_shift;

  // Sync-in only reaches the base clock when the PLL option is fused in
  assign mon_if.enable  = s_q.route_sel & PLL_OPTION_ENABLE;
  assign mon_if.div_sel = s_q.div_sel;

  sync_in_monitor #(
    .CNT_W (12)
  ) u_monitor (
    .clk     (CLK),
    .rst_n   (RST_N),
    .sync_in (SYNC_IN_PIN),
    .mon     (mon_if.monitor)
  );

  // Index order: pre-regulator, step-up, core 1, core 2, core 3
  assign reg_shift = {CORE_CONVERTER3_PHASE_SHIFT, CORE_CONVERTER2_PHASE_SHIFT,
                      CORE_CONVERTER1_PHASE_SHIFT, STEP_UP_PHASE_SHIFT,
                      PRE_REGULATOR_PHASE_SHIFT};
  assign reg_src   = {{(REG_COUNT - 1){s_q.fast_clk}},
                      PRE_REGULATOR_SLOW_SELECT ? s_q.slow_clk : s_q.fast_clk};

  genvar gi;
  for (gi = 0; gi < REG_COUNT; gi++) begin : g_shift
    regulator_phase_shift #(
      .SHIFT_W (3)
    ) u_shift (
      .clk       (CLK),
      .rst_n     (RST_N),
      .base_tick (base_tick),
      .src_clk   (reg_src[gi]),
      .shift     (reg_shift[gi]),
      .clk_out   (reg_clk[gi]),
      .start     (reg_start[gi])
    );
  end

  always_comb begin
    s_d = s_q;

    // Oscillator model: phase accumulator carry is one oscillator cycle, a base clock cycle while use_pll is clear
    inc0    = NCO_W'(trim_to_mhz(s_q.trim_eff) * INC_PER_MHZ);
    ss_prod = $signed({{(40 - NCO_W){1'b0}}, inc0}) * 40'($signed(s_q.tri_val)) * SS_NUM;
    inc_sum = $signed({{(40 - NCO_W){1'b0}}, inc0}) + (ss_prod >>> SS_DEV_SHIFT);
    nco_sum  = {1'b0, s_q.nco} + {1'b0, inc_sum[NCO_W-1:0]};
    osc_tick = nco_sum[NCO_W];
    s_d.nco  = nco_sum[NCO_W-1:0];
    fs_sum     = {1'b0, s_q.fs_nco} + {1'b0, FS_INC};
    fs_tick    = fs_sum[NCO_W];
    s_d.fs_nco = fs_sum[NCO_W-1:0];
    // New trim is taken at a carry so no half-length period appears
    if (osc_tick) begin
      s_d.trim_eff = s_q.trim;
    end

    // Triangular carrier; held at centre while disabled
    ss_step = s_q.carrier_sel ? 4'(SS_STEP_FAST) : 4'(SS_STEP_SLOW);
    if (!s_q.spread_en) begin
      s_d.tri_val  = '0;
      s_d.tri_pre  = '0;
      s_d.tri_down = 1'b0;
    end else if (s_q.tri_pre >= ss_step - 4'h1) begin
      s_d.tri_pre = '0;
      if (s_q.tri_down) begin
        s_d.tri_val  = s_q.tri_val - 7'h01;
        s_d.tri_down = ($signed(s_d.tri_val) > TRI_BOT);
      end else begin
        s_d.tri_val  = s_q.tri_val + 7'h01;
        s_d.tri_down = ($signed(s_d.tri_val) >= TRI_TOP);
      end
    end else begin
      s_d.tri_pre = s_q.tri_pre + 4'h1;
    end

    // Base clock source; entering PLL waits for a base cycle, leaving is immediate
    base_tick = s_q.use_pll ? mon_if.pll_tick : osc_tick;
    if (!mon_if.locked || mon_if.fault) begin
      s_d.use_pll = 1'b0;
    end else if (base_tick) begin
      s_d.use_pll = 1'b1;
    end

    // Fast and slow divided clocks
    if (base_tick) begin
      s_d.fast_cnt = (s_q.fast_cnt == 4'(FAST_DIV - 1)) ? 4'h0 : s_q.fast_cnt + 4'h1;
      s_d.fast_clk = s_d.fast_cnt < 4'(FAST_DIV / 2);
      s_d.slow_cnt = (s_q.slow_cnt == 6'(SLOW_DIV - 1)) ? 6'h00 : s_q.slow_cnt + 6'h01;
      s_d.slow_clk = s_d.slow_cnt < 6'(SLOW_DIV / 2);
    end

    // Diagnostic oscillator dividers
    if (osc_tick) begin
      s_d.main_cnt = (s_q.main_cnt == 5'(DIAG_DIV / 2 - 1)) ? 5'h00 : s_q.main_cnt + 5'h01;
      s_d.main_div = (s_q.main_cnt == 5'(DIAG_DIV / 2 - 1)) ? ~s_q.main_div : s_q.main_div;
    end
    if (fs_tick) begin
      s_d.fs_cnt = (s_q.fs_cnt == 5'(DIAG_DIV / 2 - 1)) ? 5'h00 : s_q.fs_cnt + 5'h01;
      s_d.fs_div = (s_q.fs_cnt == 5'(DIAG_DIV / 2 - 1)) ? ~s_q.fs_div : s_q.fs_div;
    end

    // Sync-out selection only changes while the pin is low
    if (!s_q.sync_out) begin
      s_d.out_sel_eff  = s_q.out_sel;
      s_d.out_base_eff = s_q.out_base_sel;
    end
    if (s_d.out_sel_eff != OUT_OFF && s_d.out_sel_eff <= OUT_REG_LAST) begin
      out_src = reg_clk[3'(s_d.out_sel_eff - 4'h1)];
    end else begin
      case (s_d.out_sel_eff)
        OUT_BASE:     out_src = s_d.out_base_eff ? s_q.fast_clk : s_q.slow_clk;
        OUT_MAIN_DIV: out_src = s_q.main_div & PLL_OPTION_ENABLE;
        OUT_FS_DIV:   out_src = s_q.fs_div;
        OUT_SYNC_DIV: out_src = mon_if.div_clk;
        default:      out_src = 1'b0;
      endcase
    end
    s_d.sync_out = out_src;

    // Register file
    ctrl_rd                              = '0;
    ctrl_rd[TRIM_LSB +: 4]               = s_q.trim;
    ctrl_rd[SPREAD_EN_BIT]               = s_q.spread_en;
    ctrl_rd[CARRIER_SEL_BIT]             = s_q.carrier_sel;
    ctrl_rd[DIV_SEL_BIT]                 = s_q.div_sel;
    ctrl_rd[ROUTE_SEL_BIT]               = s_q.route_sel;
    ctrl_rd[OUT_BASE_BIT]                = s_q.out_base_sel;
    ctrl_rd[OUT_SEL_LSB +: 4]            = s_q.out_sel;
    rd_word                              = '0;
    if (WB_ADR_I == CTRL_ADDR) begin
      rd_word[15:0] = ctrl_rd;
    end else if (WB_ADR_I == STATUS_ADDR) begin
      rd_word[ST_RANGE_OK_BIT] = s_q.range_ok;
      rd_word[ST_LOCKED_BIT]   = mon_if.locked;
      rd_word[ST_BASE_PLL_BIT] = s_q.use_pll;
      rd_word[ST_PLL_OPT_BIT]  = PLL_OPTION_ENABLE;
    end
    req     = WB_CYC_I & WB_STB_I & ~s_q.ack;
    s_d.ack = req;
    if (req && !WB_WE_I) begin
      s_d.dat = rd_word;
    end
    ctrl_wr = ctrl_rd;
    if (WB_SEL_I[0]) begin
      ctrl_wr[7:0] = WB_DAT_I[7:0];
    end
    if (WB_SEL_I[1]) begin
      ctrl_wr[15:8] = WB_DAT_I[15:8];
    end
    if (req && WB_WE_I && WB_ADR_I == CTRL_ADDR) begin
      // Trim steps are applied as written; pacing is software's duty
      s_d.trim         = ctrl_wr[TRIM_LSB +: 4];
      s_d.spread_en    = ctrl_wr[SPREAD_EN_BIT];
      s_d.carrier_sel  = ctrl_wr[CARRIER_SEL_BIT];
      s_d.div_sel      = ctrl_wr[DIV_SEL_BIT];
      s_d.route_sel    = ctrl_wr[ROUTE_SEL_BIT];
      s_d.out_base_sel = ctrl_wr[OUT_BASE_BIT];
      s_d.out_sel      = ctrl_wr[OUT_SEL_LSB +: 4];
      if (ctrl_wr[ROUTE_SEL_BIT] && !s_q.route_sel) begin
        s_d.range_ok = 1'b1;
      end
    end
    // A fault beats a simultaneous re-arm; routing must be set again
    if (mon_if.fault) begin
      s_d.route_sel = 1'b0;
      s_d.range_ok  = 1'b0;
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      s_q <= CM_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  assign WB_ACK_O     = s_q.ack;
  assign WB_DAT_O     = s_q.dat;
  assign SYNC_OUT_PIN = s_q.sync_out;

  assign PRE_REGULATOR_CLOCK   = reg_clk[0];
  assign STEP_UP_CLOCK         = reg_clk[1];
  assign CORE_CONVERTER1_CLOCK = reg_clk[2];
  assign CORE_CONVERTER2_CLOCK = reg_clk[3];
  assign CORE_CONVERTER3_CLOCK = reg_clk[4];

  assign PRE_REGULATOR_HS_START   = reg_start[0];
  assign CORE_CONVERTER3_HS_START = reg_start[4];
  assign CORE_CONVERTER1_LS_START = reg_start[2];
  assign CORE_CONVERTER2_LS_START = reg_start[3];
  assign STEP_UP_SWITCH_START     = reg_start[1];
endmodule
`default_nettype wire

// [sim/switcher_clock_management_asserts.sv]
`default_nettype none
module switcher_clock_management_asserts (
  // Clock and reset
  input wire logic CLK,
  input wire logic RST_N,
  // Bus handshake
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_ACK_O,
  // Regulator clocks and starts
  input wire logic PRE_REGULATOR_CLOCK,
  input wire logic CORE_CONVERTER1_CLOCK,
  input wire logic PRE_REGULATOR_HS_START,
  input wire logic CORE_CONVERTER1_LS_START,
  input wire logic CORE_CONVERTER3_CLOCK,
  input wire logic CORE_CONVERTER3_HS_START
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RST_N);

  chk_ack_next: assert property (WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O)
    else $error("ack late");
  chk_ack_single: assert property (WB_ACK_O |=> !WB_ACK_O)
    else $error("ack too long");
  // Base ticks never outrun CLK, so nine ticks span at least nine cycles
  chk_fast_gap: assert property ($rose(CORE_CONVERTER1_CLOCK) |=>
    !$rose(CORE_CONVERTER1_CLOCK) [*8]) else $error("fast clock too quick");
  chk_fast_next: assert property ($rose(CORE_CONVERTER1_CLOCK) |->
    ##[9:16] $rose(CORE_CONVERTER1_CLOCK)) else $error("fast clock too slow");
  chk_slow_next: assert property ($rose(PRE_REGULATOR_CLOCK) |->
    ##[44:80] $rose(PRE_REGULATOR_CLOCK)) else $error("slow clock period");
  chk_hs_start: assert property ($rose(PRE_REGULATOR_CLOCK) |->
    ##[0:1] PRE_REGULATOR_HS_START) else $error("high-side start missing");
  chk_hs_pulse: assert property (PRE_REGULATOR_HS_START |=>
    !PRE_REGULATOR_HS_START) else $error("high-side start too long");
  chk_ls_start: assert property ($rose(CORE_CONVERTER1_CLOCK) |->
    ##[0:1] CORE_CONVERTER1_LS_START) else $error("low-side start missing");
  chk_core3_start: assert property ($rose(CORE_CONVERTER3_CLOCK) |->
    CORE_CONVERTER3_HS_START) else $error("core three start missing");
endmodule
bind switcher_clock_management switcher_clock_management_asserts i_chk (
  .CLK, .RST_N, .WB_CYC_I, .WB_STB_I, .WB_ACK_O, .PRE_REGULATOR_CLOCK,
  .CORE_CONVERTER1_CLOCK, .PRE_REGULATOR_HS_START, .CORE_CONVERTER1_LS_START,
  .CORE_CONVERTER3_CLOCK, .CORE_CONVERTER3_HS_START
);
`default_nettype wire

// [sim/sync_source_model.sv]
`default_nettype none
module sync_source_model (
  // Clock and control
  input  wire logic       clk,
  input  wire logic       en,
  input  wire logic [7:0] half,
  // Sync-in pin
  output var  logic       pin
);
  timeunit 1ns;
  timeprecision 1ns;
  int n;
  // Stopped source: the pin falls to its pull-down level
  always @(posedge clk) begin
    if (!en) begin
      pin <= 1'b0;
      n <= 0;
    end else if (n + 1 >= half) begin
      pin <= !pin;
      n <= 0;
    end else begin
      n <= n + 1;
    end
  end
endmodule
`default_nettype wire

// [sim/switcher_clock_management_tb.sv]
`default_nettype none
module switcher_clock_management_tb
  import clock_mgmt_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
`define CHK(n, e, g) begin \
  num_checks++; \
  if ((e) !== (g)) begin \
    err_total++; \
    $display("wrong value %s exp %0h got %0h", n, e, g); \
  end \
end
  logic        CLK, RST_N, WB_CYC_I, WB_STB_I, WB_WE_I, WB_ACK_O, SYNC_IN_PIN;
  logic        SYNC_OUT_PIN, sen, x, pr, po;
  logic [3:0]  WB_ADR_I, WB_SEL_I;
  logic [31:0] WB_DAT_I, WB_DAT_O, rd_q, r;
  logic [2:0]  sp, ss, s1, s3;
  logic [7:0]  half;
  wire logic [4:0] rc;
  int          err_total, num_checks, seed, t, r2, r4, m, mn, mx, e0, e1;
  logic [3:0]  seq [20] = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h3, 4'h2, 4'h1, 4'h0, 4'hC, 4'hB,
                            4'hA, 4'h9, 4'hA, 4'hB, 4'hC, 4'h0, 4'h5, 4'h0, 4'hF, 4'h0};

  switcher_clock_management i_dut (
    .CLK, .RST_N, .WB_CYC_I, .WB_STB_I, .WB_WE_I, .WB_ADR_I, .WB_SEL_I, .WB_DAT_I,
    .WB_ACK_O, .WB_DAT_O, .SYNC_IN_PIN, .SYNC_OUT_PIN,
    .PRE_REGULATOR_PHASE_SHIFT(sp), .STEP_UP_PHASE_SHIFT(ss),
    .CORE_CONVERTER1_PHASE_SHIFT(s1), .CORE_CONVERTER2_PHASE_SHIFT(s1),
    .CORE_CONVERTER3_PHASE_SHIFT(s3), .PRE_REGULATOR_SLOW_SELECT(1'b1),
    .PLL_OPTION_ENABLE(po), .PRE_REGULATOR_CLOCK(rc[0]), .STEP_UP_CLOCK(rc[1]),
    .CORE_CONVERTER1_CLOCK(rc[2]), .CORE_CONVERTER2_CLOCK(rc[3]),
    .CORE_CONVERTER3_CLOCK(rc[4]), .PRE_REGULATOR_HS_START(), .CORE_CONVERTER3_HS_START(),
    .CORE_CONVERTER1_LS_START(), .CORE_CONVERTER2_LS_START(), .STEP_UP_SWITCH_START()
  );
  sync_source_model i_src (.clk(CLK), .en(sen), .half(half), .pin(SYNC_IN_PIN));

  task automatic end_sim();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial begin
    CLK = 1'b0;
    forever #20 CLK = ~CLK;
  end

  // First core converter three rise after each core converter one rise
  always @(posedge CLK) begin
    t <= t + 1;
    if ($rose(rc[2])) r2 <= t;
    if ($rose(rc[4]) && ($rose(rc[2]) || r4 < r2)) r4 <= t;
    if (t > 60000) begin
      err_total++;
      end_sim();
    end
  end

  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    WB_CYC_I <= 1'b1;
    WB_STB_I <= 1'b1;
    WB_WE_I <= w;
    WB_ADR_I <= a;
    WB_DAT_I <= d;
    WB_SEL_I <= 4'h3;
    @(posedge CLK);
    while (WB_ACK_O !== 1'b1) @(posedge CLK);
    rd_q = WB_DAT_O;
    WB_CYC_I <= 1'b0;
    WB_STB_I <= 1'b0;
    @(posedge CLK);
  endtask

  // Upper bytes carry noise that the control register must ignore
  task automatic wr(input logic [15:0] v);
    r = $random(seed);
    bus(1'b1, CTRL_ADDR, {r[31:16], v});
  endtask

  task automatic meas(input logic w, input int n);
    logic p;
    int k;
    p = 1'b1;
    k = -1;
    m = 0;
    while (k < n) begin
      @(posedge CLK);
      if (k >= 0) m++;
      if ((w ? SYNC_OUT_PIN : rc[2]) && !p) k++;
      p = w ? SYNC_OUT_PIN : rc[2];
    end
  endtask

  function automatic logic near(input int a, input int b);
    return (a - b) * (a - b) * 2500 <= b * b;
  endfunction

  function automatic int mhz(input logic [3:0] c);
    if (c <= 4'h4) return 20 + c;
    if (c >= 4'h9 && c <= 4'hC) return 7 + c;
    return 20;
  endfunction

  initial begin
    seed = 40;
    r = $random(seed);
    {sp, ss, s1, s3} = r[11:0];
    {RST_N, WB_CYC_I, WB_STB_I, WB_WE_I, sen, po} = 6'h01;
    {WB_ADR_I, WB_SEL_I, WB_DAT_I, half} = {8'h00, 32'h0, 8'h1A};
    repeat (12) @(posedge CLK);
    RST_N <= 1'b1;
    @(posedge CLK);
    bus(1'b0, CTRL_ADDR, 32'h0);
    `CHK("ctrl_reset", 32'h0, rd_q)
    bus(1'b1, 4'h8, r);
    bus(1'b1, STATUS_ADDR, r);
    bus(1'b0, 4'h8, 32'h0);
    `CHK("unmapped", 32'h0, rd_q)
    bus(1'b0, STATUS_ADDR, 32'h0);
    `CHK("status_reset", 32'h9, rd_q)
    foreach (seq[i]) begin
      wr({12'h000, seq[i]});
      repeat (250) @(posedge CLK);
      meas(1'b0, 40);
      `CHK("trim_rate", 1'b1, near(m, 9000 / mhz(seq[i])))
    end
    @(r2);
    m = r2;
    repeat (11) @(posedge CLK);
    e0 = r4 - m;
    e1 = (int'(s3) - int'(s1) + 9) % 9;
    `CHK("phase_lag", 1'b1, e0 >= e1 && e0 <= e1 + e1 / 4 + 1)
    // Trim stays at code 0 while spreading
    for (int k = 0; k < 3; k++) begin
      wr(k == 2 ? 16'h0000 : (k == 1 ? 16'h0030 : 16'h0010));
      repeat (250) @(posedge CLK);
      mn = 999;
      mx = 0;
      repeat (25) begin
        meas(1'b0, 8);
        mn = m < mn ? m : mn;
        mx = m > mx ? m : mx;
      end
      `CHK("spread_span", k < 2, mx - mn >= 4)
    end
    for (int k = 0; k < 17; k++) begin
      wr(k == 16 ? 16'h6000 : {4'(k), 12'h100});
      repeat (70) @(posedge CLK);
      if (k inside {6, 7, 8, 16}) begin
        meas(1'b1, 8);
        `CHK("out_rate", 1'b1, near(m, k == 6 ? 90 : (k == 16 ? 440 : 480)))
      end else if (k != 9) begin
        {e0, e1} = '0;
        pr = k inside {[1:5]} ? rc[k-1] : 1'b0;
        repeat (120) begin
          @(posedge CLK);
          x = k inside {[1:5]} ? rc[k-1] : 1'b0;
          e0 += int'(SYNC_OUT_PIN !== x);
          e1 += int'(SYNC_OUT_PIN !== pr);
          pr = x;
        end
        `CHK("out_follow", 1'b1, k inside {[1:5]} ? e1 == 0 : e0 == 0)
      end
    end
    wr(16'h9000);
    sen <= 1'b1;
    repeat (200) @(posedge CLK);
    wr(16'h9080);
    repeat (2600) @(posedge CLK);
    bus(1'b0, STATUS_ADDR, 32'h0);
    `CHK("locked", 32'hF, rd_q)
    meas(1'b0, 40);
    `CHK("pll_rate", 1'b1, near(m, 390))
    meas(1'b1, 8);
    `CHK("sync_div_out", 1'b1, near(m, 416))
    // Last edge may land as the source stops: 75 idle cycles plus two register stages
    sen <= 1'b0;
    repeat (77) @(posedge CLK);
    bus(1'b0, STATUS_ADDR, 32'h0);
    `CHK("loss", 2'b00, {rd_q[2], rd_q[0]})
    bus(1'b0, CTRL_ADDR, 32'h0);
    `CHK("route_clear", 32'h9000, rd_q)
    sen <= 1'b1;
    repeat (300) @(posedge CLK);
    bus(1'b0, STATUS_ADDR, 32'h0);
    `CHK("stays_bad", 1'b0, rd_q[0])
    wr(16'h9080);
    repeat (300) @(posedge CLK);
    bus(1'b0, STATUS_ADDR, 32'h0);
    `CHK("recover", 1'b1, rd_q[0])
    half <= 8'h14;
    repeat (50) @(posedge CLK);
    bus(1'b0, STATUS_ADDR, 32'h0);
    `CHK("short_dev", 1'b0, rd_q[0])
    // Fast source through the divide-by-six path
    wr(16'h9040);
    half <= 8'h05;
    repeat (100) @(posedge CLK);
    wr(16'h90C0);
    repeat (300) @(posedge CLK);
    bus(1'b0, STATUS_ADDR, 32'h0);
    `CHK("div6_ok", 1'b1, rd_q[0])
    meas(1'b1, 8);
    `CHK("div6_out", 1'b1, near(m, 480))
    // Without the fused option an out-of-range source must be ignored
    po <= 1'b0;
    wr(16'h9080);
    repeat (300) @(posedge CLK);
    bus(1'b0, STATUS_ADDR, 32'h0);
    `CHK("no_pll_opt", 32'h1, rd_q)
    end_sim();
  end
endmodule
`default_nettype wire
